// ==== common/spsf_pkg.sv ====
package spsf_pkg;
  // register byte offsets
  localparam logic [11:0] PROTOCOL_CONTROL_OFS = 12'h05C;
  localparam logic [11:0] PROTOCOL_IRQEN_OFS   = 12'h060;
  localparam logic [11:0] PROTOCOL_STATUS_OFS  = 12'h064;
  localparam logic [11:0] XFER_CONTROL_OFS     = 12'h068;
  // protocol_status fields
  localparam int ST_UNDERRUN  = 18;
  localparam int ST_BUSY      = 17;
  localparam int ST_PINLEVEL  = 16;
  localparam int ST_SELACT    = 9;
  localparam int ST_SELINA    = 8;
  localparam int ST_BITERR    = 6;
  localparam int ST_TIMEOUT   = 5;
  localparam int ST_RXEND     = 4;
  localparam int ST_RXSTART   = 3;
  localparam int ST_TXEND     = 2;
  localparam int ST_TXSTART   = 1;
  localparam logic [31:0] STATUS_RESET = 32'h0000_0000;
  localparam logic [31:0] STATUS_W1C_MASK = 32'h0000_037E;
  // protocol_control fields
  localparam int CT_ENABLE   = 31;
  localparam int CT_UDRLEVEL = 28;
  localparam int CT_TOCNT_LO = 16;
  localparam int CT_TOCNT_W  = 10;
  localparam int CT_SLAVE    = 0;
  localparam logic [31:0] CONTROL_RESET = 32'h0000_0300;
  localparam logic [31:0] CONTROL_MASK  = 32'h93FF_7FCF;
  localparam logic [31:0] IRQEN_MASK    = 32'h0000_000F;
  localparam logic [31:0] IRQEN_RESET   = 32'h0000_0000;
  // xfer_control: word length (bits-1) and transmit word
  localparam int XC_WLEN_LO = 16;
  localparam int XC_WLEN_W  = 4;
  localparam logic [31:0] XFER_RESET = 32'h0007_0000;
  localparam int WORD_MAX = 16;
endpackage

// ==== design/spsf_edge_sync.sv ====
// two-flop synchroniser with edge detection on the second stage
module spsf_edge_sync
  import spsf_pkg::*;
#(
  parameter logic IDLE = 1'b0 // rest level of the pin, so reset shows no false edge
)
(
  input  wire logic clk_sys,
  input  wire logic sys_rst,
  input  wire logic pinIn,
  output logic      level,
  output logic      rise,
  output logic      fall
);
  logic meta;
  logic sync;
  logic prev;
  logic next_meta;
  logic next_sync;
  logic next_prev;

  // shift chain
  always_comb
  begin
    next_meta = pinIn;
    next_sync = meta;
    next_prev = sync;
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      meta <= IDLE;
      sync <= IDLE;
      prev <= IDLE;
    end
    else
    begin
      meta <= next_meta;
      sync <= next_sync;
      prev <= next_prev;
    end
  end

  assign level = sync;
  assign rise  = sync & ~prev;
  assign fall  = ~sync & prev;
endmodule

// ==== design/spsf_status_flags.sv ====
// Design decision made here: the APB register port.
module spsf_status_flags
  import spsf_pkg::*;
#(
  parameter int WORD_BITS = WORD_MAX
)
(
  input  wire logic        clk_sys,
  input  wire logic        sys_rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        spiClk,
  input  wire logic        spiSelectN,
  input  wire logic        spiDataIn,
  output logic             spiDataOut,
  output logic             spiDataOutEn,
  output logic             protocolIrq
);
  initial
  begin
    if (WORD_BITS < 4 || WORD_BITS > WORD_MAX)
      $error("WORD_BITS out of range");
  end

  logic [31:0] protocolControl;
  logic [31:0] irqEnable;
  logic [31:0] xferControl;
  logic [31:0] status;
  logic        txFull;
  logic        shifterFull;
  logic [15:0] txShift;
  logic [15:0] rxShift;
  logic [4:0]  bitCount;
  logic        inWord;
  logic        underrun;
  logic [9:0]  toCount;
  logic        masterActive;
  logic [31:0] next_protocolControl;
  logic [31:0] next_irqEnable;
  logic [31:0] next_xferControl;
  logic [31:0] next_status;
  logic [31:0] next_prdata;
  logic        next_pready;
  logic        next_pslverr;
  logic        next_txFull;
  logic        next_shifterFull;
  logic [15:0] next_txShift;
  logic [15:0] next_rxShift;
  logic [4:0]  next_bitCount;
  logic        next_inWord;
  logic        next_underrun;
  logic [9:0]  next_toCount;
  logic        next_masterActive;
  logic        next_spiDataOut;
  logic        next_spiDataOutEn;
  logic        next_protocolIrq;

  logic selPin;
  logic selRise;
  logic selFall;
  logic clkLevel;
  logic clkRise;
  logic clkFall;
  logic dinLevel;

  // synchronise the link pins
  spsf_edge_sync #(.IDLE(1'b1)) uSel (.clk_sys(clk_sys), .sys_rst(sys_rst), .pinIn(spiSelectN),
    .level(selPin), .rise(selRise), .fall(selFall));
  spsf_edge_sync uClk (.clk_sys(clk_sys), .sys_rst(sys_rst), .pinIn(spiClk),
    .level(clkLevel), .rise(clkRise), .fall(clkFall));
  spsf_edge_sync uDin (.clk_sys(clk_sys), .sys_rst(sys_rst), .pinIn(spiDataIn),
    .level(dinLevel), .rise(), .fall());

  function automatic logic isAccess(input logic [11:0] ofs);
    isAccess = psel && penable && (paddr == ofs);
  endfunction

  // next link bit: the under-run level, or word bit (length - 1 - bits sent)
  function automatic logic pickBit(input logic udr, input logic lvl, input logic [15:0] word,
                                   input logic [4:0] len, input logic [4:0] sent);
    pickBit = udr ? lvl : word[4'(len - 5'd1 - sent)];
  endfunction

  logic enabled;
  logic slaveMode;
  logic selected;
  logic selActEv;
  logic selInaEv;
  logic sampleEdge;
  logic shiftEdge;
  logic [4:0] wordLen;
  logic timeoutEv;
  logic txWrite;
  logic udrLevel;

  // decoded control and events
  always_comb
  begin
    enabled    = protocolControl[CT_ENABLE];
    slaveMode  = protocolControl[CT_SLAVE];
    selected   = ~selPin;
    selActEv   = slaveMode && selFall;
    selInaEv   = slaveMode && selRise;
    sampleEdge = clkRise && selected;
    shiftEdge  = clkFall && selected;
    wordLen    = 5'(xferControl[XC_WLEN_LO +: XC_WLEN_W]) + 5'd1;
    timeoutEv  = slaveMode && enabled && inWord
      && protocolControl[CT_TOCNT_LO +: CT_TOCNT_W] != 10'd0
      && toCount == protocolControl[CT_TOCNT_LO +: CT_TOCNT_W];
    txWrite    = isAccess(XFER_CONTROL_OFS) && pwrite;
    udrLevel   = protocolControl[CT_UDRLEVEL];
  end

  // link engine, flags and bus slave next state
  always_comb
  begin
    logic [31:0] evt;
    evt = 32'h0000_0000;
    next_protocolControl = protocolControl;
    next_irqEnable    = irqEnable;
    next_xferControl  = xferControl;
    next_txFull       = txFull;
    next_shifterFull  = shifterFull;
    next_txShift      = txShift;
    next_rxShift      = rxShift;
    next_bitCount     = bitCount;
    next_inWord       = inWord;
    next_underrun     = underrun;
    next_toCount      = toCount;
    next_masterActive = masterActive && enabled && !slaveMode;
    next_spiDataOut   = spiDataOut;
    next_spiDataOutEn = slaveMode && enabled && selected;
    if (txWrite)
      next_txFull = 1'b1;
    // shift clock activity
    if (clkRise || clkFall)
      next_toCount = 10'd0;
    else if (inWord && toCount != 10'h3FF)
      next_toCount = toCount + 10'd1;
    // a word opens as select goes active, so the first bit stands before the first rise
    if (enabled && selActEv && !inWord)
    begin
      next_inWord = 1'b1;
      next_bitCount = 5'd0;
      next_toCount = 10'd0;
      evt[ST_RXSTART] = 1'b1;
      evt[ST_TXSTART] = 1'b1;
      next_shifterFull = txFull;
      next_underrun = !txFull;
      if (txFull)
      begin
        next_txShift = xferControl[15:0];
        next_txFull = txWrite;
      end
      next_spiDataOut = pickBit(next_underrun, udrLevel, next_txShift, wordLen, 5'd0);
    end
    // later bits, or the under-run level, go out on the falling link clock
    if (slaveMode && enabled && shiftEdge && inWord)
      next_spiDataOut = pickBit(underrun, udrLevel, txShift, wordLen, bitCount);
    if (slaveMode && enabled && sampleEdge && inWord)
    begin
      next_rxShift = {rxShift[14:0], dinLevel};
      next_bitCount = bitCount + 5'd1;
      if (bitCount + 5'd1 == wordLen)
      begin
        next_inWord = 1'b0;
        next_shifterFull = 1'b0;
        evt[ST_RXEND] = 1'b1;
        evt[ST_TXEND] = 1'b1;
      end
    end
    // aborted word: timeout or deselect before full length
    if (timeoutEv || (selInaEv && inWord))
    begin
      next_inWord = 1'b0;
      next_shifterFull = 1'b0;
      evt[ST_BITERR] = bitCount != wordLen;
    end
    evt[ST_TIMEOUT] = timeoutEv;
    evt[ST_SELACT]  = selActEv;
    evt[ST_SELINA]  = selInaEv;
    if (!slaveMode && enabled && txFull && !masterActive)
    begin
      next_masterActive = 1'b1;
      next_txFull = txWrite;
    end
    // sticky flags: set beats the write-1 clear
    next_status = status;
    if (isAccess(PROTOCOL_STATUS_OFS) && pwrite)
      next_status = status & ~(pwdata & STATUS_W1C_MASK);
    next_status = (next_status | evt) & STATUS_W1C_MASK;
    next_status[ST_UNDERRUN] = next_underrun && slaveMode;
    next_status[ST_BUSY] = enabled && (next_txFull
      || (!slaveMode && next_masterActive)
      || (slaveMode && selected && next_inWord)
      || (slaveMode && next_shifterFull));
    next_status[ST_PINLEVEL] = slaveMode && selPin;
    // register writes
    if (psel && penable && pwrite)
    begin
      if (paddr == PROTOCOL_CONTROL_OFS)
        next_protocolControl = pwdata & CONTROL_MASK;
      if (paddr == PROTOCOL_IRQEN_OFS)
        next_irqEnable = pwdata & IRQEN_MASK;
      if (paddr == XFER_CONTROL_OFS)
        next_xferControl = pwdata;
    end
    // reads
    next_pready  = psel && !pready;
    next_pslverr = 1'b0;
    next_prdata  = 32'h0000_0000;
    if (psel && !pready)
    begin
      case (paddr)
        PROTOCOL_CONTROL_OFS: next_prdata = protocolControl;
        PROTOCOL_IRQEN_OFS:   next_prdata = irqEnable;
        PROTOCOL_STATUS_OFS:  next_prdata = status;
        XFER_CONTROL_OFS:     next_prdata = {xferControl[31:16], rxShift};
        default:              next_pslverr = 1'b1;
      endcase
    end
    next_protocolIrq = (status[ST_SELINA] && irqEnable[0])
      || (status[ST_SELACT] && irqEnable[1])
      || (status[ST_TIMEOUT] && irqEnable[2])
      || (status[ST_BITERR] && irqEnable[3]);
  end

  // register everything
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      protocolControl <= CONTROL_RESET;
      irqEnable       <= IRQEN_RESET;
      xferControl     <= XFER_RESET;
      status          <= STATUS_RESET;
      prdata          <= 32'h0000_0000;
      pready          <= 1'b0;
      pslverr         <= 1'b0;
      txFull          <= 1'b0;
      shifterFull     <= 1'b0;
      txShift         <= 16'h0000;
      rxShift         <= 16'h0000;
      bitCount        <= 5'h00;
      inWord          <= 1'b0;
      underrun        <= 1'b0;
      toCount         <= 10'h000;
      masterActive    <= 1'b0;
      spiDataOut      <= 1'b0;
      spiDataOutEn    <= 1'b0;
      protocolIrq     <= 1'b0;
    end
    else
    begin
      protocolControl <= next_protocolControl;
      irqEnable       <= next_irqEnable;
      xferControl     <= next_xferControl;
      status          <= next_status;
      prdata          <= next_prdata;
      pready          <= next_pready;
      pslverr         <= next_pslverr;
      txFull          <= next_txFull;
      shifterFull     <= next_shifterFull;
      txShift         <= next_txShift;
      rxShift         <= next_rxShift;
      bitCount        <= next_bitCount;
      inWord          <= next_inWord;
      underrun        <= next_underrun;
      toCount         <= next_toCount;
      masterActive    <= next_masterActive;
      spiDataOut      <= next_spiDataOut;
      spiDataOutEn    <= next_spiDataOutEn;
      protocolIrq     <= next_protocolIrq;
    end
  end
endmodule

// ==== test/spsf_far_master.sv ====
module spsf_far_master
(
  output logic      spiClk,
  output logic      spiSelectN,
  output logic      spiDataIn,
  input  wire logic spiDataOut
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] rxWord;
  // clock parked low and stopped between frames
  initial
  begin
    spiClk = 1'b0;
    spiSelectN = 1'b1;
    spiDataIn = 1'b0;
    rxWord = 16'h0000;
  end
  // one frame, msb first, 64 ns clock; linger keeps select after the last bit
  task automatic frame(input logic [15:0] tx, input int nBits, input int linger);
    #3; // keep every pin change clear of the system clock edge
    spiSelectN = 1'b0;
    for (int i = nBits - 1; i >= 0; i--)
    begin
      spiDataIn = tx[i];
      #32;
      spiClk = 1'b1;
      rxWord = {rxWord[14:0], spiDataOut};
      #32;
      spiClk = 1'b0;
    end
    #(linger);
    spiSelectN = 1'b1;
    spiDataIn = ~spiDataIn; // released line must not keep its value
    #200;
  endtask
endmodule

// ==== test/spsf_status_flags_monitor.sv ====
module spsf_status_flags_monitor
  import spsf_pkg::*;
(
  input wire logic        clk_sys,
  input wire logic        sys_rst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        spiClk,
  input wire logic        spiSelectN,
  input wire logic        spiDataIn,
  input wire logic        spiDataOut,
  input wire logic        spiDataOutEn,
  input wire logic        protocolIrq
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  logic mapped;
  // the four words the block answers for
  assign mapped = paddr inside {PROTOCOL_CONTROL_OFS, PROTOCOL_IRQEN_OFS,
                                PROTOCOL_STATUS_OFS, XFER_CONTROL_OFS};
  // apb answer timing and refusal
  chk_setup_ready: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  chk_ready_pulse: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  chk_ready_cause: assert property (pready |-> $past(psel && !penable))
    else $error("ready without setup");
  chk_err_map: assert property (pready |-> pslverr == !mapped)
    else $error("slave error does not match address");
  chk_err_zero: assert property (pslverr && !pwrite |-> prdata == 32'h0000_0000)
    else $error("refused read returns data");
  // reserved status bits always read zero
  chk_status_rsvd: assert property (pready && !pwrite && paddr == PROTOCOL_STATUS_OFS
    |-> (prdata & ~32'h0007_037E) == 32'h0000_0000) else $error("reserved status bit set");
  // data output only driven while selected
  chk_outen_idle: assert property (spiSelectN [*5] |-> !spiDataOutEn)
    else $error("data driven while deselected");
  chk_outen_drop: assert property ($rose(spiSelectN) |-> ##[1:5] !spiDataOutEn)
    else $error("data enable stuck after deselect");
  cover property (pslverr);
  cover property ($rose(spiDataOutEn));
  cover property ($rose(protocolIrq));
  cover property (pready && pwrite && paddr == PROTOCOL_STATUS_OFS);
endmodule

bind spsf_status_flags spsf_status_flags_monitor u_mon (
  .clk_sys(clk_sys), .sys_rst(sys_rst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .spiClk(spiClk), .spiSelectN(spiSelectN),
  .spiDataIn(spiDataIn), .spiDataOut(spiDataOut), .spiDataOutEn(spiDataOutEn),
  .protocolIrq(protocolIrq)
);

// ==== test/testbench.sv ====
module testbench
  import spsf_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_sys = 1'b0;
  logic        sys_rst = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic        pready, pslverr, spiClk, spiSelectN, spiDataIn, spiDataOut;
  logic        spiDataOutEn, protocolIrq;
  int          n_fail = 0;
  int          n_tests = 0;
  int          seed = 32'hc36e;
  logic [31:0] expQ[$];
  logic [31:0] mskQ[$];
  logic [15:0] w;
  // enabled slave, under-run level 1, time-out after 20 cycles
  localparam logic [31:0] CTRL = 32'h9014_0001;

  always #4 clk_sys = ~clk_sys;

  spsf_status_flags #(.WORD_BITS(16)) DUT (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .spiClk(spiClk), .spiSelectN(spiSelectN),
    .spiDataIn(spiDataIn), .spiDataOut(spiDataOut), .spiDataOutEn(spiDataOutEn),
    .protocolIrq(protocolIrq));
  spsf_far_master u_far (.spiClk(spiClk), .spiSelectN(spiSelectN),
    .spiDataIn(spiDataIn), .spiDataOut(spiDataOut));

  task automatic cmp(input string what, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e)
    begin
      n_fail++;
      $display("BAD %s expected %h seen %h", what, e, g);
    end
  endtask
  // one transfer: setup, then access held until pready
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do
      @(posedge clk_sys);
    while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [31:0] m);
    expQ.push_back(e & m);
    mskQ.push_back(m);
    apb(1'b0, a, 32'h0000_0000);
  endtask
  task automatic irq(input logic e);
    repeat (8) @(posedge clk_sys);
    cmp("protocolIrq", {31'h0, e}, {31'h0, protocolIrq});
  endtask
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // each finished read is checked against the oldest note
  always @(posedge clk_sys)
    if (psel && penable && pready === 1'b1 && !pwrite && expQ.size() > 0)
      cmp("prdata", expQ.pop_front(), prdata & mskQ.pop_front());
  initial
  begin
    #400000;
    n_fail++;
    close_out();
  end

  initial
  begin
    repeat (6) @(posedge clk_sys);
    sys_rst <= 1'b0;
    rd(PROTOCOL_STATUS_OFS, STATUS_RESET, 32'hFFFE_FFFF);
    rd(PROTOCOL_CONTROL_OFS, CONTROL_RESET, 32'hFFFF_FFFF);
    rd(XFER_CONTROL_OFS, XFER_RESET, 32'hFFFF_FFFF);
    rd(12'h070, 32'h0000_0000, 32'hFFFF_FFFF);
    $display("reset test done");
    apb(1'b1, PROTOCOL_CONTROL_OFS, CTRL);
    rd(PROTOCOL_CONTROL_OFS, CTRL, 32'hFFFF_FFFF);
    apb(1'b1, PROTOCOL_IRQEN_OFS, IRQEN_MASK);
    apb(1'b1, XFER_CONTROL_OFS, 32'h000F_A55A);
    rd(PROTOCOL_STATUS_OFS, 32'h0003_0000, 32'h0003_0000);
    u_far.frame(16'h3C96, 16, 0);
    cmp("miso", 32'h0000_A55A, {16'h0, u_far.rxWord});
    rd(XFER_CONTROL_OFS, 32'h0000_3C96, 32'h0000_FFFF);
    rd(PROTOCOL_STATUS_OFS, 32'h0001_031E, 32'h0003_037E);
    irq(1'b1);
    apb(1'b1, PROTOCOL_STATUS_OFS, STATUS_W1C_MASK);
    rd(PROTOCOL_STATUS_OFS, 32'h0000_0000, STATUS_W1C_MASK);
    irq(1'b0);
    $display("loaded word test done");
    // nothing loaded: output parks at the chosen level
    u_far.frame(16'h0F0F, 16, 0);
    cmp("miso", 32'h0000_FFFF, {16'h0, u_far.rxWord});
    rd(PROTOCOL_STATUS_OFS, 32'h0004_0000, 32'h0004_0000);
    $display("underrun test done");
    apb(1'b1, PROTOCOL_IRQEN_OFS, 32'h0000_0000);
    apb(1'b1, PROTOCOL_STATUS_OFS, STATUS_W1C_MASK);
    u_far.frame(16'h0005, 3, 0);
    rd(PROTOCOL_STATUS_OFS, 32'h0000_0040, 32'h0000_0060);
    apb(1'b1, PROTOCOL_STATUS_OFS, STATUS_W1C_MASK);
    u_far.frame(16'h0005, 3, 400);
    rd(PROTOCOL_STATUS_OFS, 32'h0000_0060, 32'h0000_0060);
    irq(1'b0);
    $display("error event test done");
    repeat (3)
    begin
      w = 16'($random(seed));
      apb(1'b1, XFER_CONTROL_OFS, {12'h000, 4'hF, w});
      u_far.frame(~w, 16, 0);
      cmp("miso", {16'h0, w}, {16'h0, u_far.rxWord});
      rd(XFER_CONTROL_OFS, {16'h0, ~w}, 32'h0000_FFFF);
    end
    $display("random word test done");
    // master mode: a loaded word keeps the port busy
    apb(1'b1, PROTOCOL_CONTROL_OFS, 32'h8000_0000);
    apb(1'b1, XFER_CONTROL_OFS, 32'h000F_1234);
    rd(PROTOCOL_STATUS_OFS, 32'h0002_0000, 32'h0007_0000);
    $display("master busy test done");
    @(posedge clk_sys);
    sys_rst <= 1'b1;
    repeat (3) @(posedge clk_sys);
    sys_rst <= 1'b0;
    rd(PROTOCOL_STATUS_OFS, STATUS_RESET, 32'hFFFE_FFFF);
    $display("second reset test done");
    close_out();
  end
endmodule
